// *** bench/clkmon_checker.sv ***
// Purpose: port checks for the clock monitor
// Assumes: sees only top-level ports
// Notes: gap counter bounds capture spacing
`timescale 1ns/1ps
module clkmon_checker (
  // clock, reset, control
  input wire        CLK,
  input wire        NRST,
  input wire        MEAS_EN,
  input wire [15:0] UPPER_LIMIT,
  input wire [15:0] LOWER_LIMIT,
  // results
  input wire [15:0] PULSE_COUNT_BUFFER,
  input wire        FREQ_ERROR,
  input wire        MEAS_END,
  input wire        COUNT_OVERFLOW
);
  reg [5:0] gap_q; // cycles since last capture, saturating
  // count cycles between captures
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) gap_q <= 6'h3F;
    else gap_q <= MEAS_END ? 6'h00 : gap_q + {5'h00, gap_q != 6'h3F};
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_err_with_end: assert property (FREQ_ERROR |-> MEAS_END) else $error("error flag alone");
  a_err_limits: assert property (MEAS_END |-> FREQ_ERROR == (PULSE_COUNT_BUFFER > UPPER_LIMIT
    || PULSE_COUNT_BUFFER < LOWER_LIMIT)) else $error("error flag wrong");
  a_buf_hold: assert property (!MEAS_END |-> $stable(PULSE_COUNT_BUFFER)) else $error("buffer moved");
  a_end_pulse: assert property (MEAS_END |=> !MEAS_END) else $error("end too long");
  a_ovf_pulse: assert property (COUNT_OVERFLOW |=> !COUNT_OVERFLOW) else $error("overflow too long");
  a_idle_quiet: assert property (!MEAS_EN [*2] |-> !MEAS_END && !COUNT_OVERFLOW) else $error("event idle");
  a_window_min: assert property (MEAS_END |-> gap_q >= 6'h1F) else $error("window short");
  a_reset_clear: assert property (disable iff (1'b0) !NRST |-> PULSE_COUNT_BUFFER == 16'h0000
    && !MEAS_END && !FREQ_ERROR && !COUNT_OVERFLOW) else $error("reset not clear");
endmodule // clkmon_checker
bind clkmon_top clkmon_checker i_clkmon_checker (.CLK, .NRST, .MEAS_EN, .UPPER_LIMIT, .LOWER_LIMIT,
  .PULSE_COUNT_BUFFER, .FREQ_ERROR, .MEAS_END, .COUNT_OVERFLOW);

// *** bench/clkmon_src_model.sv ***
// Purpose: free-running source oscillators for the monitor
// Assumes: levels change only on CLK edges
// Notes: source i half period i+1 cycles, pin 64 cycles
`timescale 1ns/1ps
module clkmon_src_model (
  // clock and reset
  input  wire       clk,
  input  wire       nrst,
  // source levels
  output reg  [7:0] src = 8'h00
);
  integer cnt [0:7]; // half-period counters
  integer i;
  // each source toggles at its own rate
  always @(posedge clk or negedge nrst) begin
    for (i = 0; i < 8; i = i + 1) begin
      if (!nrst) begin
        cnt[i] <= 0;
        src[i] <= 1'b0;
      end else if (cnt[i] == ((i == 7) ? 63 : i)) begin
        cnt[i] <= 0;
        src[i] <= ~src[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule // clkmon_src_model

// *** bench/tb.sv ***
// Purpose: self-checking bench for the clock monitor
// Assumes: sources come from the oscillator model
// Notes: config table, random limits per window
`timescale 1ns/1ps
module tb;
  localparam [167:0] TBL = {14'h3800, 14'h0404, 14'h38AD, 14'h3942, 14'h398F, 14'h0A4C, 14'h2814,
    14'h1209, 14'h20B0, 14'h3058, 14'h0607, 14'h181C}; // src,div,flt,edge,msrc,mdiv
  reg         clk, nrst, meas_en;
  reg  [13:0] cfg;
  reg  [15:0] up_lim, lo_lim, got;
  reg  [31:0] rnd;
  wire [7:0]  src;
  wire [15:0] cnt_buf;
  wire        f_err, m_end, c_ovf;
  integer     errors, num_checks, k, t, e;
  reg         ovf_seen = 1'b0; // sticky: any overflow pulse seen
  clkmon_src_model i_clkmon_src_model (.clk(clk), .nrst(nrst), .src(src));
  clkmon_top i_clkmon_top (.CLK(clk), .NRST(nrst), .MAIN_OSC(src[0]), .SUB_CLOCK(src[1]),
    .HIGH_OSC(src[2]), .MID_OSC(src[3]), .LOW_OSC(src[4]), .PERIPHERAL_BUS_CLOCK_B(src[5]),
    .WATCHDOG_DEDICATED_OSC(src[6]), .EXT_REF_CLOCK_PIN(src[7]), .MEAS_EN(meas_en),
    .REF_SRC(cfg[13:11]), .REF_DIV(cfg[10:9]), .REF_FILTER(cfg[8:7]), .REF_EDGE(cfg[6:5]),
    .MEAS_SRC(cfg[4:2]), .MEAS_DIV(cfg[1:0]), .UPPER_LIMIT(up_lim), .LOWER_LIMIT(lo_lim),
    .PULSE_COUNT_BUFFER(cnt_buf), .FREQ_ERROR(f_err), .MEAS_END(m_end), .COUNT_OVERFLOW(c_ovf));
  // overflow lasts one cycle, so it is latched for the window checks
  always @(posedge clk) if (nrst && c_ovf !== 1'b0) ovf_seen <= 1'b1;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // window cycles over measured tick period
  function integer exp_cnt(input [13:0] c);
    integer w;
    begin
      w = (c[13:11] == 3'h7 ? 128 : 2 * c[13:11] + 2) *
        (c[10:9] == 2'h0 ? 32 : c[10:9] == 2'h1 ? 128 : c[10:9] == 2'h2 ? 1024 : 8192);
      if (c[6:5] == 2'h2) w = w / 2;
      exp_cnt = w / ((c[4:2] == 3'h7 ? 128 : 2 * c[4:2] + 2) *
        (c[1:0] == 2'h0 ? 1 : c[1:0] == 2'h1 ? 4 : c[1:0] == 2'h2 ? 8 : 32));
    end
  endfunction
  task check(input [15:0] seen, input [15:0] expv, input [8*6:1] what);
    begin
      num_checks = num_checks + 1;
      if (seen !== expv) begin
        errors = errors + 1;
        $display("wrong value %0s expected %0h seen %0h", what, expv, seen);
      end
    end
  endtask
  task summarize; begin
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  end endtask
  // wait for one capture and judge it; counts stay far below wrap
  task run_window; begin
    t = 0;
    while (m_end !== 1'b1 && t < 40000) begin
      @(posedge clk);
      #1 t = t + 1;
    end
    got = cnt_buf;
    check(t < 40000, 1, "done");
    check(got + 1 >= e && got <= e + 1, 1, "count");
    check(f_err, rnd[1:0] == 2'h1 || rnd[1:0] == 2'h2, "ferr");
    check(ovf_seen, 16'h0000, "ovf");
    @(posedge clk);
    #1 check(m_end, 0, "pulse");
  end endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog against a hung window
  initial begin
    #900000;
    errors = errors + 1;
    summarize;
  end
  initial begin
    errors = 0;
    num_checks = 0;
    rnd = 32'd78800;
    {nrst, meas_en, cfg, up_lim, lo_lim} = {2'h0, 14'h0000, 16'hFFFF, 16'h0000};
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    check(cnt_buf, 16'h0000, "rstbuf");
    for (k = 0; k < 12; k = k + 1) begin
      rnd = lfsr(rnd);
      cfg = TBL[k*14 +: 14];
      e = exp_cnt(cfg);
      // mode 1 limit below count, mode 2 above, else inside
      lo_lim = rnd[1:0] == 2'h2 ? e + 2 : rnd[1:0] == 2'h1 ? 0 : e - 2;
      up_lim = rnd[1:0] == 2'h1 ? e - 2 : rnd[1:0] == 2'h2 ? 16'hFFFF : e + 2 + rnd[7:4];
      @(posedge clk);
      #1 meas_en = 1'b1;
      run_window;
      meas_en = 1'b0;
      repeat (4) @(posedge clk);
      #1 check(cnt_buf, got, "hold");
    end
    // reset before the first reference edge opens the window: buffer clears, next window counts afresh
    meas_en = 1'b1;
    repeat (300) @(posedge clk);
    #1 nrst = 1'b0;
    @(posedge clk);
    #1 check(cnt_buf, 16'h0000, "rstbuf");
    nrst = 1'b1;
    run_window;
    // no-edge setting: enabled yet never captures
    meas_en = 1'b0;
    cfg = 14'h0060;
    @(posedge clk);
    #1 meas_en = 1'b1;
    t = 0;
    repeat (300) begin
      @(posedge clk);
      #1 t = t + (m_end !== 1'b0);
    end
    check(t[15:0], 16'h0000, "noedge");
    summarize;
  end
endmodule // tb

// *** rtl/clkmon_defines.vh ***
// Purpose: constants for the clock accuracy monitor
// Assumes: one system clock, sources arrive as synchronous levels
// Notes: selector encodings follow the order of the source list
`ifndef CLKMON_DEFINES_VH
`define CLKMON_DEFINES_VH
`define CLKMON_CNT_W        16
`define CLKMON_SRC_W        3
`define CLKMON_SRC_MAIN     3'h0
`define CLKMON_SRC_SUB      3'h1
`define CLKMON_SRC_HIGH     3'h2
`define CLKMON_SRC_MID      3'h3
`define CLKMON_SRC_LOW      3'h4
`define CLKMON_SRC_PBCLK    3'h5
`define CLKMON_SRC_WDOSC    3'h6
`define CLKMON_SRC_EXTPIN   3'h7
`define CLKMON_RDIV_32      2'h0
`define CLKMON_RDIV_128     2'h1
`define CLKMON_RDIV_1024    2'h2
`define CLKMON_RDIV_8192    2'h3
`define CLKMON_MDIV_1       2'h0
`define CLKMON_MDIV_4       2'h1
`define CLKMON_MDIV_8       2'h2
`define CLKMON_MDIV_32      2'h3
`define CLKMON_FLT_OFF      2'h0
`define CLKMON_FLT_1        2'h1
`define CLKMON_FLT_4        2'h2
`define CLKMON_FLT_16       2'h3
`define CLKMON_EDGE_RISE    2'h0
`define CLKMON_EDGE_FALL    2'h1
`define CLKMON_EDGE_BOTH    2'h2
`define CLKMON_FLT_MATCH    2'h3
`endif

// *** rtl/clkmon_top.v ***
// Purpose: clock frequency accuracy monitor
// Assumes: all source clocks are sampled levels synchronous to CLK
// Notes: events are one-cycle pulses; count buffer holds the last window
`timescale 1ns/1ps
`include "clkmon_defines.vh"

module clkmon_top (
  // clock and reset
  input  wire        CLK,
  input  wire        NRST,
  // clock sources as levels
  input  wire        MAIN_OSC,
  input  wire        SUB_CLOCK,
  input  wire        HIGH_OSC,
  input  wire        MID_OSC,
  input  wire        LOW_OSC,
  input  wire        PERIPHERAL_BUS_CLOCK_B,
  input  wire        WATCHDOG_DEDICATED_OSC,
  input  wire        EXT_REF_CLOCK_PIN,
  // configuration
  input  wire        MEAS_EN,
  input  wire [2:0]  REF_SRC,
  input  wire [1:0]  REF_DIV,
  input  wire [1:0]  REF_FILTER,
  input  wire [1:0]  REF_EDGE,
  input  wire [2:0]  MEAS_SRC,
  input  wire [1:0]  MEAS_DIV,
  input  wire [15:0] UPPER_LIMIT,
  input  wire [15:0] LOWER_LIMIT,
  // results and events
  output wire [15:0] PULSE_COUNT_BUFFER,
  output wire        FREQ_ERROR,
  output wire        MEAS_END,
  output wire        COUNT_OVERFLOW
);

  // internal state and selected levels
  wire [7:0]  src_vec;         // all sources in selector order
  reg         ref_raw;         // selected reference level
  reg         meas_raw;        // selected measured level
  reg         meas_prev_q;     // measured level last cycle
  reg  [4:0]  meas_pre_q;      // measured prescaler
  reg  [12:0] ref_pre_q;       // reference prescaler
  reg  [3:0]  flt_div_q;       // filter sample-rate divider
  reg  [2:0]  flt_sh_q;        // filter sample history
  reg         flt_q;           // filtered pin level
  reg         ref_lvl_prev_q;  // reference level last cycle
  reg         ref_div_q;       // divided reference level
  reg         ref_div_prev_q;  // divided reference last cycle
  reg  [15:0] cnt_q;           // running pulse count
  reg  [15:0] buf_q;           // captured count
  reg         ferr_q;          // error pulse
  reg         mend_q;          // end pulse
  reg         ovf_q;           // overflow pulse
  // bit index equals the source selector code
  assign src_vec = {EXT_REF_CLOCK_PIN, WATCHDOG_DEDICATED_OSC, PERIPHERAL_BUS_CLOCK_B,
                    LOW_OSC, MID_OSC, HIGH_OSC, SUB_CLOCK, MAIN_OSC};

  // source selection for both clocks
  always @* begin
    ref_raw  = src_vec[REF_SRC];
    meas_raw = src_vec[MEAS_SRC];
  end

  // measured rising edge and its prescaled tick
  // prescaler counts from enable, so the first tick needs N rises
  wire meas_rise = meas_raw & ~meas_prev_q;
  reg  meas_tick;
  always @* begin
    case (MEAS_DIV)
      `CLKMON_MDIV_1: meas_tick = meas_rise;
      `CLKMON_MDIV_4: meas_tick = meas_rise & (meas_pre_q[1:0] == 2'h3);
      `CLKMON_MDIV_8: meas_tick = meas_rise & (meas_pre_q[2:0] == 3'h7);
      default:        meas_tick = meas_rise & (meas_pre_q == 5'h1F);
    endcase
  end

  // filter sample strobe every CLK cycle, /4 or /16
  // divider runs free, strobe phase does not follow enable
  reg flt_stb;
  always @* begin
    case (REF_FILTER)
      `CLKMON_FLT_1: flt_stb = 1'b1;
      `CLKMON_FLT_4: flt_stb = (flt_div_q[1:0] == 2'h3);
      default:       flt_stb = (flt_div_q == 4'hF);
    endcase
  end

  // reference level: filter only applies to the pin
  // a filtered pin lags the raw pin by about three samples
  wire use_flt = (REF_SRC == `CLKMON_SRC_EXTPIN) && (REF_FILTER != `CLKMON_FLT_OFF);
  wire ref_lvl = use_flt ? flt_q : ref_raw;

  // reference prescaler terminal values
  reg ref_wrap;
  wire ref_rise = ref_lvl & ~ref_lvl_prev_q;
  always @* begin
    case (REF_DIV)
      `CLKMON_RDIV_32:   ref_wrap = (ref_pre_q[3:0] == 4'hF);
      `CLKMON_RDIV_128:  ref_wrap = (ref_pre_q[5:0] == 6'h3F);
      `CLKMON_RDIV_1024: ref_wrap = (ref_pre_q[8:0] == 9'h1FF);
      default:           ref_wrap = (ref_pre_q[11:0] == 12'hFFF);
    endcase
  end

  // edge detect on the divided reference
  // code 3 selects no edges, so the window never opens
  reg ref_edge;
  always @* begin
    case (REF_EDGE)
      `CLKMON_EDGE_RISE: ref_edge = ref_div_q & ~ref_div_prev_q;
      `CLKMON_EDGE_FALL: ref_edge = ~ref_div_q & ref_div_prev_q;
      `CLKMON_EDGE_BOTH: ref_edge = ref_div_q ^ ref_div_prev_q;
      default:           ref_edge = 1'b0;
    endcase
  end

  // first valid edge only opens the window
  // later edges close one window and open the next
  reg armed_q;
  wire cap = MEAS_EN & armed_q & ref_edge;

  // prescalers, filter and edge history
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      meas_prev_q    <= 1'b0;
      meas_pre_q     <= 5'h00;
      ref_pre_q      <= 13'h0000;
      flt_div_q      <= 4'h0;
      flt_sh_q       <= 3'h0;
      flt_q          <= 1'b0;
      ref_lvl_prev_q <= 1'b0;
      ref_div_q      <= 1'b0;
      ref_div_prev_q <= 1'b0;
    end else begin
      meas_prev_q    <= meas_raw;
      ref_lvl_prev_q <= ref_lvl;
      ref_div_prev_q <= ref_div_q;
      flt_div_q      <= flt_div_q + 4'h1;
      if (!MEAS_EN) begin
        // idle: hold dividers cleared
        meas_pre_q <= 5'h00;
        ref_pre_q  <= 13'h0000;
        ref_div_q  <= 1'b0;
      end else begin
        if (meas_rise)
          meas_pre_q <= meas_pre_q + 5'h01;
        if (ref_rise) begin
          // toggle at half period gives divide by N
          if (ref_wrap) begin
            ref_pre_q <= 13'h0000;
            ref_div_q <= ~ref_div_q;
          end else begin
            ref_pre_q <= ref_pre_q + 13'h0001;
          end
        end
      end
      // filter: accept level after three equal samples
      if (flt_stb) begin
        flt_sh_q <= {flt_sh_q[1:0], EXT_REF_CLOCK_PIN};
        if (flt_sh_q == 3'h7)
          flt_q <= 1'b1;
        else if (flt_sh_q == 3'h0)
          flt_q <= 1'b0;
      end
    end
  end

  // window counter, capture, limit check and events
  // a tick that lands in the capture cycle is dropped, not carried
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      armed_q <= 1'b0;
      cnt_q   <= 16'h0000;
      buf_q   <= 16'h0000;
      ferr_q  <= 1'b0;
      mend_q  <= 1'b0;
      ovf_q   <= 1'b0;
    end else begin
      ferr_q <= 1'b0;
      mend_q <= 1'b0;
      ovf_q  <= 1'b0;
      if (!MEAS_EN) begin
        // measurement stopped; buffer keeps last result
        armed_q <= 1'b0;
        cnt_q   <= 16'h0000;
      end else if (ref_edge) begin
        armed_q <= 1'b1;
        cnt_q   <= 16'h0000;
        if (cap) begin
          buf_q  <= cnt_q;
          mend_q <= 1'b1;
          ferr_q <= (cnt_q > UPPER_LIMIT) | (cnt_q < LOWER_LIMIT);
        end
      end else if (armed_q && meas_tick) begin
        cnt_q <= cnt_q + 16'h0001;
        if (cnt_q == 16'hFFFF)
          ovf_q <= 1'b1;
      end
    end
  end

  // results straight from flip-flops
  assign PULSE_COUNT_BUFFER = buf_q;
  assign FREQ_ERROR         = ferr_q;
  assign MEAS_END           = mend_q;
  assign COUNT_OVERFLOW     = ovf_q;

endmodule // clkmon_top
